// ==== peb_bank.sv ====
/*
 Power enable register bank: seven 16-bit enable registers behind an AXI4-Lite
 slave, a key register guarding protected bits, and a regulator status register.
 Assumes aclk at 20 MHz, synchronous reset, and a power state machine pulse
 sm_reset that returns marked bits to their defaults.
*/
// The AXI4-Lite interface to the registers was chosen for this implementation.
//
// Overview of operation
// - Codec registers held reset while master enable clear
// - Regulator enables are requests; actual state reported
// - Limit switch, four linear, six buck enables
// - State machine reset restores marked bits
// - Tick, oscillator, charger default one, key-guarded
// - Charger off forces charge current zero
// - Tick enable stops or runs real-time clock
// - Bit ten switches crystal oscillator
// - Backup supply routed to pin when set
// - Comparator and auxiliary converter enables default zero
// - Reference divider select and string enable
// - Mic bias high impedance when disabled
// - Tie-off buffer force and shutdown drain
// - Highpass filter resets one; sysclk enable
// - Zero-cross timeout clock and DAC enables
// - Input amplifiers, gain stages, input mixers
// - Outputs three/four and output mixers
// - Second LED sink, state machine reset
// - First LED sink, default zero, state machine reset
`timescale 1ns/1ps
`default_nettype none

module peb_bank
	import peb_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sm_reset,
	input wire logic [10:0] converter_permit,
	input wire logic [31:0] s_awaddr,
	input wire logic [2:0] s_awprot,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [31:0] s_araddr,
	input wire logic [2:0] s_arprot,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	output logic codec_reset_n,
	output peb_analogue_t analogue_ctl,
	output logic [15:0] input_mixer_ctl,
	output logic [15:0] output_ctl,
	output logic [15:0] converter_ctl,
	output logic clock_calendar_tick_on,
	output logic crystal_osc_on,
	output logic charger_on,
	output logic charge_current_zero,
	output logic backup_supply_out_on,
	output logic aux_converter_on,
	output logic [3:0] digital_comparator_on,
	output logic limit_switch_on,
	output logic [3:0] linear_reg_on,
	output logic [5:0] buck_on,
	output logic led_sink1_on,
	output logic led_sink2_on,
	output logic mic_bias_oe
);

	logic [15:0] reg_q [PEB_NREG];
	logic [15:0] reg_d [PEB_NREG];
	logic [15:0] stat_q;
	logic key_q;
	logic key_d;
	logic aw_full_q;
	logic w_full_q;
	peb_addr_t aw_q;
	peb_wdata_t w_q;
	logic [31:0] rdata_d;
	logic [1:0] rresp_d;

	function automatic logic [15:0] mask_of(input int i);
		case (i)
			0: mask_of = PEB_MASK_ANALOGUE;
			1: mask_of = PEB_MASK_INMIX;
			2: mask_of = PEB_MASK_OUTPUT;
			3: mask_of = PEB_MASK_CONV;
			4: mask_of = PEB_MASK_SYSFN;
			5: mask_of = PEB_MASK_REGS;
			default: mask_of = PEB_MASK_SINKS;
		endcase
	endfunction

	function automatic logic [15:0] rst_of(input int i);
		case (i)
			3: rst_of = PEB_RST_CONV;
			4: rst_of = PEB_RST_SYSFN;
			default: rst_of = PEB_RST_ANALOGUE;
		endcase
	endfunction

	function automatic logic [15:0] smr_of(input int i);
		case (i)
			4: smr_of = PEB_SMR_SYSFN;
			5: smr_of = PEB_SMR_REGS;
			6: smr_of = PEB_SMR_SINKS;
			default: smr_of = 16'h0000;
		endcase
	endfunction

	// Word index of a byte address; anything outside 0x000..0x3ff is unmapped
	function automatic logic [7:0] idx_of(input logic [31:0] a);
		idx_of = (a[31:10] == 22'h0) ? a[9:2] : 8'hff;
	endfunction

	wire do_write = aw_full_q && w_full_q && !s_bvalid;
	wire [7:0] widx = idx_of(aw_q.addr);
	wire [7:0] ridx = idx_of(s_araddr);
	wire [15:0] wval = w_q.data[15:0];
	wire [1:0] wlanes = w_q.strb[1:0];
	wire w_is_key = do_write && (widx == PEB_IDX_KEY);
	wire w_is_bank = do_write && (widx >= PEB_IDX_ANALOGUE) && (widx <= PEB_IDX_SINKS);
	wire w_is_ro = do_write && (widx == PEB_IDX_REGSTAT);
	wire w_ok = w_is_key || w_is_bank || w_is_ro;
	wire [2:0] wsel = 3'(widx - PEB_IDX_ANALOGUE);
	wire [15:0] lane_mask = {{8{wlanes[1]}}, {8{wlanes[0]}}};

	// Next channel state, from which the readies are registered
	wire aw_take = s_awvalid && s_awready;
	wire w_take = s_wvalid && s_wready;
	wire ar_take = s_arvalid && s_arready;
	wire aw_full_d = do_write ? 1'b0 : (aw_full_q || aw_take);
	wire w_full_d = do_write ? 1'b0 : (w_full_q || w_take);
	wire bvalid_d = do_write || (s_bvalid && !s_bready);
	wire rvalid_d = ar_take || (s_rvalid && !s_rready);

	// Key opens on writing the key value, closes on any other key write or after one guarded write
	always_comb begin
		key_d = key_q;
		if (w_is_key) begin
			key_d = (wval == PEB_KEY_VALUE) && (wlanes == 2'b11);
		end else if (w_is_bank && wsel == 3'd4) begin
			key_d = 1'b0;
		end
	end

	always_comb begin
		logic [15:0] wm;
		wm = 16'h0000;
		for (int i = 0; i < PEB_NREG; i++) begin
			wm = mask_of(i) & lane_mask;
			if (i == 4 && !key_q) begin
				wm = wm & ~PEB_KEY_BITS;
			end
			reg_d[i] = reg_q[i];
			if (w_is_bank && wsel == 3'(i)) begin
				reg_d[i] = (reg_q[i] & ~wm) | (wval & wm);
			end
			// Restore comes after the write, so it wins on marked bits only and other writes still land
			if (sm_reset) begin
				reg_d[i] = (reg_d[i] & ~smr_of(i)) | (rst_of(i) & smr_of(i));
			end
		end
	end

	always_ff @(posedge aclk) begin
		for (int i = 0; i < PEB_NREG; i++) begin
			if (!aresetn) begin
				reg_q[i] <= rst_of(i);
			end else begin
				reg_q[i] <= reg_d[i];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_q <= 1'b0;
		end else begin
			key_q <= key_d;
		end
	end

	// Converter status: a request only takes effect where internal conditions permit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_q <= 16'h0000;
		end else begin
			// One permit per converter; a cleared permit keeps that converter off whatever is requested
			stat_q <= {5'h00, reg_q[5][15] & converter_permit[10], reg_q[5][11:8] & converter_permit[9:6],
				reg_q[5][5:0] & converter_permit[5:0]};
		end
	end

	// Write channel capture; address and data in either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_q <= '0;
			w_q <= '0;
			s_bvalid <= 1'b0;
			s_bresp <= PEB_RESP_OKAY;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_full_q <= 1'b1;
				aw_q <= '{addr: s_awaddr, prot: s_awprot};
			end
			if (s_wvalid && s_wready) begin
				w_full_q <= 1'b1;
				w_q <= '{data: s_wdata, strb: s_wstrb};
			end
			if (do_write) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= w_ok ? PEB_RESP_OKAY : PEB_RESP_SLVERR;
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	// Readies come from flip-flops; they stay low through reset and rise one cycle after release
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_awready <= 1'b0;
			s_wready <= 1'b0;
			s_arready <= 1'b0;
		end else begin
			s_awready <= !aw_full_d && !bvalid_d;
			s_wready <= !w_full_d && !bvalid_d;
			s_arready <= !rvalid_d;
		end
	end

	// Read decode
	always_comb begin
		rdata_d = 32'h0000_0000;
		rresp_d = PEB_RESP_OKAY;
		if (ridx >= PEB_IDX_ANALOGUE && ridx <= PEB_IDX_SINKS) begin
			rdata_d = {16'h0000, reg_q[3'(ridx - PEB_IDX_ANALOGUE)]};
		end else if (ridx == PEB_IDX_REGSTAT) begin
			rdata_d = {16'h0000, stat_q};
		end else if (ridx == PEB_IDX_KEY) begin
			rdata_d = {31'h0, key_q};
		end else begin
			rresp_d = PEB_RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= PEB_RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rdata <= rdata_d;
			s_rresp <= rresp_d;
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
		end
	end

	// Enable outputs, registered so they come straight from flip-flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			codec_reset_n <= 1'b0;
			analogue_ctl <= '0;
			input_mixer_ctl <= 16'h0000;
			output_ctl <= 16'h0000;
			converter_ctl <= PEB_RST_CONV;
			clock_calendar_tick_on <= 1'b1;
			crystal_osc_on <= 1'b1;
			charger_on <= 1'b1;
			charge_current_zero <= 1'b0;
			backup_supply_out_on <= 1'b0;
			aux_converter_on <= 1'b0;
			digital_comparator_on <= 4'h0;
			limit_switch_on <= 1'b0;
			linear_reg_on <= 4'h0;
			buck_on <= 6'h00;
			led_sink1_on <= 1'b0;
			led_sink2_on <= 1'b0;
			mic_bias_oe <= 1'b0;
		end else begin
			codec_reset_n <= reg_q[4][PEB_B_CODEC];
			analogue_ctl.vmid_sel <= reg_q[0][PEB_B_VMID +: 2];
			analogue_ctl.midrail_string_on <= reg_q[0][PEB_B_MIDRAIL];
			analogue_ctl.mic_bias_on <= reg_q[0][PEB_B_MICB];
			analogue_ctl.analogue_bias_on <= reg_q[0][PEB_B_BIAS];
			analogue_ctl.mic_detect_on <= reg_q[0][PEB_B_MICDET];
			analogue_ctl.fast_shutdown_drain <= reg_q[0][PEB_B_DRAIN];
			analogue_ctl.tieoff_buffer_force <= reg_q[0][PEB_B_VBUF];
			mic_bias_oe <= reg_q[0][PEB_B_MICB];
			input_mixer_ctl <= reg_q[1];
			output_ctl <= reg_q[2];
			// ADC pair relies on the host writing both enables at once
			converter_ctl <= reg_q[3];
			clock_calendar_tick_on <= reg_q[4][PEB_B_TICK];
			crystal_osc_on <= reg_q[4][PEB_B_OSC];
			charger_on <= reg_q[4][PEB_B_CHG];
			charge_current_zero <= !reg_q[4][PEB_B_CHG];
			backup_supply_out_on <= reg_q[4][PEB_B_VRTC];
			aux_converter_on <= reg_q[4][PEB_B_AUX];
			digital_comparator_on <= reg_q[4][3:0];
			limit_switch_on <= stat_q[10];
			linear_reg_on <= stat_q[9:6];
			buck_on <= stat_q[5:0];
			led_sink1_on <= reg_q[6][0];
			led_sink2_on <= reg_q[6][1];
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	codec_hold_a: assert property (!reg_q[4][PEB_B_CODEC] |=> !codec_reset_n)
		else $error("codec not held in reset");
	charge_zero_a: assert property (##1 charge_current_zero == !$past(reg_q[4][PEB_B_CHG]) && charger_on == $past(reg_q[4][PEB_B_CHG]))
		else $error("charge current forced while charger on");
	key_guard_a: assert property (!key_q && !sm_reset |=> reg_q[4][11:9] == $past(reg_q[4][11:9]))
		else $error("guarded bits changed without key");
	sm_restore_a: assert property (sm_reset |=> reg_q[6] == 16'h0000 && reg_q[5] == 16'h0000)
		else $error("state machine reset did not restore");
	unlisted_zero_a: assert property (reg_q[6][15:2] == 14'h0 && reg_q[2][6:4] == 3'h0)
		else $error("unlisted bit set");
	status_req_a: assert property (stat_q[5:0] != 6'h00 |-> (stat_q[5:0] & ~$past(reg_q[5][5:0])) == 6'h00)
		else $error("converter on without request");
	bias_drive_a: assert property (reg_q[0][PEB_B_MICB] |=> mic_bias_oe)
		else $error("mic bias not driven");
	tick_follow_a: assert property (##1 clock_calendar_tick_on == $past(reg_q[4][PEB_B_TICK]))
		else $error("tick enable not followed");
	led_sink_a: assert property (##1 led_sink1_on == $past(reg_q[6][0]))
		else $error("sink enable not followed");
	codec_run_a: assert property (reg_q[4][PEB_B_CODEC] |=> codec_reset_n)
		else $error("codec not released");
	osc_follow_a: assert property (##1 crystal_osc_on == $past(reg_q[4][PEB_B_OSC]))
		else $error("oscillator enable not followed");
	backup_follow_a: assert property (##1 backup_supply_out_on == $past(reg_q[4][PEB_B_VRTC]))
		else $error("backup supply enable not followed");
	aux_follow_a: assert property (##1 aux_converter_on == $past(reg_q[4][PEB_B_AUX]))
		else $error("auxiliary converter enable not followed");
	sm_keybits_a: assert property (sm_reset |=> reg_q[4] == PEB_RST_SYSFN)
		else $error("system register not restored");
	ls_request_a: assert property (stat_q[10] |-> $past(reg_q[5][15]))
		else $error("limit switch on without request");
	ready_busy_a: assert property (s_bvalid |-> !s_awready && !s_wready)
		else $error("write accepted while response pending");

	write_cov_c: cover property (do_write && w_is_bank);
	key_cov_c: cover property (key_q && w_is_bank && wsel == 3'd4);
	smr_cov_c: cover property (sm_reset);
	read_cov_c: cover property (s_rvalid && s_rready);
	both_cov_c: cover property (s_awvalid && s_awready && s_wvalid && s_wready);

endmodule : peb_bank

`default_nettype wire

// ==== peb_pkg.sv ====
/*
 Package for the power enable register bank: register indices, field positions,
 reset values, writable masks and the AXI4-Lite carrier structs.
 Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
`default_nettype none

package peb_pkg;

	// Printed offsets are register indices; byte address is four times the index
	localparam logic [7:0] PEB_IDX_ANALOGUE = 8'h08;
	localparam logic [7:0] PEB_IDX_INMIX = 8'h09;
	localparam logic [7:0] PEB_IDX_OUTPUT = 8'h0a;
	localparam logic [7:0] PEB_IDX_CONV = 8'h0b;
	localparam logic [7:0] PEB_IDX_SYSFN = 8'h0c;
	localparam logic [7:0] PEB_IDX_REGS = 8'h0d;
	localparam logic [7:0] PEB_IDX_SINKS = 8'h0e;
	localparam logic [7:0] PEB_IDX_REGSTAT = 8'h0f;
	localparam logic [7:0] PEB_IDX_KEY = 8'h07;
	localparam int PEB_NREG = 7;

	// Writable bit masks per register
	localparam logic [15:0] PEB_MASK_ANALOGUE = 16'h2537;
	localparam logic [15:0] PEB_MASK_INMIX = 16'h0ff3;
	localparam logic [15:0] PEB_MASK_OUTPUT = 16'h008f;
	localparam logic [15:0] PEB_MASK_CONV = 16'h613c;
	localparam logic [15:0] PEB_MASK_SYSFN = 16'h1f8f;
	localparam logic [15:0] PEB_MASK_REGS = 16'h8f3f;
	localparam logic [15:0] PEB_MASK_SINKS = 16'h0003;

	// Values after reset
	localparam logic [15:0] PEB_RST_ANALOGUE = 16'h0000;
	localparam logic [15:0] PEB_RST_INMIX = 16'h0000;
	localparam logic [15:0] PEB_RST_OUTPUT = 16'h0000;
	localparam logic [15:0] PEB_RST_CONV = 16'h2000;
	localparam logic [15:0] PEB_RST_SYSFN = 16'h0e00;
	localparam logic [15:0] PEB_RST_REGS = 16'h0000;
	localparam logic [15:0] PEB_RST_SINKS = 16'h0000;

	// Bits returned to default by the power state machine reset
	localparam logic [15:0] PEB_SMR_SYSFN = 16'h1f8f;
	localparam logic [15:0] PEB_SMR_REGS = 16'h8f3f;
	localparam logic [15:0] PEB_SMR_SINKS = 16'h0003;

	// Key-guarded bits and key value
	localparam logic [15:0] PEB_KEY_BITS = 16'h0e00;
	localparam logic [15:0] PEB_KEY_VALUE = 16'h0bad;

	// Field positions
	localparam int PEB_B_VMID = 0;
	localparam int PEB_B_MIDRAIL = 2;
	localparam int PEB_B_MICB = 4;
	localparam int PEB_B_BIAS = 5;
	localparam int PEB_B_MICDET = 8;
	localparam int PEB_B_DRAIN = 10;
	localparam int PEB_B_VBUF = 13;
	localparam int PEB_B_CODEC = 12;
	localparam int PEB_B_TICK = 11;
	localparam int PEB_B_OSC = 10;
	localparam int PEB_B_CHG = 9;
	localparam int PEB_B_VRTC = 8;
	localparam int PEB_B_AUX = 7;
	localparam int PEB_B_HPF = 13;
	localparam int PEB_B_SYSCLK = 14;
	localparam int PEB_B_TOCLK = 8;
	localparam int PEB_B_DACR = 5;
	localparam int PEB_B_DACL = 4;
	localparam int PEB_B_ADCR = 3;
	localparam int PEB_B_ADCL = 2;
	localparam int PEB_B_LS = 15;
	localparam int PEB_B_LDO = 8;
	localparam int PEB_B_BUCK = 0;

	localparam logic [1:0] PEB_RESP_OKAY = 2'b00;
	localparam logic [1:0] PEB_RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic [31:0] addr;
		logic [2:0] prot;
	} peb_addr_t;

	typedef struct packed {
		logic [31:0] data;
		logic [3:0] strb;
	} peb_wdata_t;

	typedef struct packed {
		logic [1:0] vmid_sel;
		logic midrail_string_on;
		logic mic_bias_on;
		logic analogue_bias_on;
		logic mic_detect_on;
		logic fast_shutdown_drain;
		logic tieoff_buffer_force;
	} peb_analogue_t;

endpackage : peb_pkg

`default_nettype wire

// ==== test_power_enable_register_bank.sv ====
/*
 Self-checking testbench for peb_bank: register traffic over AXI4-Lite, key guard,
 converter permits and the power state machine reset.
 Assumes the package constants and a 50 ns clock with synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module test_power_enable_register_bank
	import peb_pkg::*;
();
	logic aclk = 1'b0;
	logic aresetn, sm_reset, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, codec_reset_n;
	logic tick, osc, chg, czero, bkp, aux, ls, s1, s2, mboe;
	logic [10:0] permit;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0] wstrb, dcmp, lin;
	logic [2:0] prot;
	logic [1:0] bresp, rresp;
	logic [5:0] buck;
	logic [15:0] imx, oc, cc;
	peb_analogue_t an;
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [7:0] idx_a [7] = '{PEB_IDX_ANALOGUE, PEB_IDX_INMIX, PEB_IDX_OUTPUT, PEB_IDX_CONV,
		PEB_IDX_SYSFN, PEB_IDX_REGS, PEB_IDX_SINKS};
	logic [15:0] rst_a [7] = '{PEB_RST_ANALOGUE, PEB_RST_INMIX, PEB_RST_OUTPUT, PEB_RST_CONV,
		PEB_RST_SYSFN, PEB_RST_REGS, PEB_RST_SINKS};
	logic [15:0] msk_a [7] = '{PEB_MASK_ANALOGUE, PEB_MASK_INMIX, PEB_MASK_OUTPUT, PEB_MASK_CONV,
		PEB_MASK_SYSFN, PEB_MASK_REGS, PEB_MASK_SINKS};

	peb_bank dut_u (.aclk(aclk), .aresetn(aresetn), .sm_reset(sm_reset), .converter_permit(permit),
		.s_awaddr(awaddr), .s_awprot(prot), .s_awvalid(awvalid), .s_awready(awready),
		.s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
		.s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
		.s_arprot(prot), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
		.s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .codec_reset_n(codec_reset_n),
		.analogue_ctl(an), .input_mixer_ctl(imx), .output_ctl(oc), .converter_ctl(cc),
		.clock_calendar_tick_on(tick), .crystal_osc_on(osc), .charger_on(chg),
		.charge_current_zero(czero), .backup_supply_out_on(bkp), .aux_converter_on(aux),
		.digital_comparator_on(dcmp), .limit_switch_on(ls), .linear_reg_on(lin), .buck_on(buck),
		.led_sink1_on(s1), .led_sink2_on(s2), .mic_bias_oe(mboe));

	always #25 aclk = ~aclk;

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// A run that stalls on a handshake ends here instead of hanging
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			results();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask

	function automatic logic [31:0] ba(input logic [7:0] i);
		return {22'h0, i, 2'b00};
	endfunction

	// Address and data are offered together; each is dropped only at its own handshake
	task automatic wr(input logic [7:0] i, input logic [15:0] d, input logic [1:0] er);
		logic ad;
		logic wd;
		@(posedge aclk);
		awaddr <= ba(i);
		wdata <= {16'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ad = 1'b0;
		wd = 1'b0;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er}, "write response");
	endtask

	task automatic rd(input logic [7:0] i, input logic [15:0] e, input logic [1:0] er);
		@(posedge aclk);
		araddr <= ba(i);
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, {16'h0, e}, "read data");
		chk({30'h0, rresp}, {30'h0, er}, "read response");
	endtask

	// Registered outputs lag by up to two cycles, so three edges leave margin
	task automatic settle;
		repeat (3) @(posedge aclk);
	endtask

	task automatic t_reset;
		for (int i = 0; i < 7; i++) begin
			rd(idx_a[i], rst_a[i], PEB_RESP_OKAY);
		end
		chk({29'h0, tick, osc, chg}, 32'h7, "key bit outputs");
		chk({31'h0, codec_reset_n}, 32'h0, "codec reset");
		chk({31'h0, mboe}, 32'h0, "mic bias drive");
		$display("test reset done");
	endtask

	task automatic t_rw;
		for (int i = 0; i < 7; i++) begin
			if (i != 4 && i != 5) begin
				wr(idx_a[i], 16'hffff, PEB_RESP_OKAY);
				rd(idx_a[i], msk_a[i], PEB_RESP_OKAY);
			end
		end
		settle();
		chk({24'h0, an}, 32'hff, "analogue fields");
		chk({16'h0, imx}, 32'h0ff3, "input mixer");
		chk({16'h0, oc}, 32'h008f, "outputs");
		chk({16'h0, cc}, 32'h613c, "converters");
		chk({30'h0, mboe, s2}, 32'h3, "bias drive and sink");
		wr(PEB_IDX_ANALOGUE, 16'h0000, PEB_RESP_OKAY);
		wr(PEB_IDX_CONV, 16'h000c, PEB_RESP_OKAY);
		settle();
		chk({31'h0, mboe}, 32'h0, "bias released");
		chk({16'h0, cc}, 32'h000c, "adc pair");
		$display("test readwrite done");
	endtask

	task automatic t_key;
		wr(PEB_IDX_SYSFN, 16'h0000, PEB_RESP_OKAY);
		rd(PEB_IDX_SYSFN, 16'h0e00, PEB_RESP_OKAY);
		wr(PEB_IDX_SYSFN, 16'hffff, PEB_RESP_OKAY);
		rd(PEB_IDX_SYSFN, 16'h1f8f, PEB_RESP_OKAY);
		settle();
		chk({25'h0, codec_reset_n, bkp, aux, dcmp}, 32'h7f, "system outputs");
		wr(PEB_IDX_KEY, PEB_KEY_VALUE, PEB_RESP_OKAY);
		wr(PEB_IDX_SYSFN, 16'h1000, PEB_RESP_OKAY);
		rd(PEB_IDX_SYSFN, 16'h1000, PEB_RESP_OKAY);
		settle();
		chk({28'h0, tick, osc, chg, czero}, 32'h1, "keyed off");
		chk({31'h0, codec_reset_n}, 32'h1, "codec running");
		// Key closes after one write, so the set key bits are refused here
		wr(PEB_IDX_SYSFN, 16'h0e00, PEB_RESP_OKAY);
		rd(PEB_IDX_SYSFN, 16'h0000, PEB_RESP_OKAY);
		settle();
		chk({31'h0, codec_reset_n}, 32'h0, "codec held");
		$display("test key done");
	endtask

	task automatic t_reg;
		wr(PEB_IDX_REGS, 16'hffff, PEB_RESP_OKAY);
		rd(PEB_IDX_REGS, 16'h8f3f, PEB_RESP_OKAY);
		settle();
		chk({21'h0, ls, lin, buck}, 32'h03e5, "actual converters");
		rd(PEB_IDX_REGSTAT, 16'h03e5, PEB_RESP_OKAY);
		permit <= 11'h7ff;
		settle();
		chk({31'h0, ls}, 32'h1, "limit switch permitted");
		$display("test regulators done");
	endtask

	task automatic t_sm;
		@(posedge aclk);
		sm_reset <= 1'b1;
		// Restore held across a write: an unmarked register still takes the write
		wr(PEB_IDX_ANALOGUE, 16'h0010, PEB_RESP_OKAY);
		sm_reset <= 1'b0;
		rd(PEB_IDX_ANALOGUE, 16'h0010, PEB_RESP_OKAY);
		rd(PEB_IDX_SYSFN, 16'h0e00, PEB_RESP_OKAY);
		rd(PEB_IDX_REGS, 16'h0000, PEB_RESP_OKAY);
		rd(PEB_IDX_SINKS, 16'h0000, PEB_RESP_OKAY);
		rd(PEB_IDX_CONV, 16'h000c, PEB_RESP_OKAY);
		settle();
		chk({28'h0, tick, ls, s1, s2}, 32'h8, "restored outputs");
		wr(8'h20, 16'hffff, PEB_RESP_SLVERR);
		rd(8'h20, 16'h0000, PEB_RESP_SLVERR);
		$display("test state reset done");
	endtask

	initial begin
		aresetn <= 1'b0;
		sm_reset <= 1'b0;
		permit <= 11'h3e5;
		awaddr <= 32'h0;
		wdata <= 32'h0;
		araddr <= 32'h0;
		wstrb <= 4'h3;
		prot <= 3'h0;
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b0;
		arvalid <= 1'b0;
		rready <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_rw();
		t_key();
		t_reg();
		t_sm();
		results();
	end
endmodule // test_power_enable_register_bank

`default_nettype wire
